// ===== stp_port.sv
// serial toggle handshake port: control/status words and two byte arrays
// assumes apb master on pclk and a serial byte engine on the same clock
//
// Summary of operation
// - control word, status word, 64-byte arrays
// - port flips tx accepted after sending bytes
// - port sets input length, flips rx request
// - no new receive data until rx accepted
// - init blocks traffic and empties the input array; output array keeps its bytes
// - init accepted set when init done
// - init accepted cleared once request is low
// - buffer full shown, further bytes dropped
// - status upper field gives valid byte count
`timescale 1ns/1ps
module stp_port
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // serial transmit bytes
    output logic      [7:0]           tx_data,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    // serial receive bytes
    input  wire logic [7:0]           rx_data,
    input  wire logic                 rx_valid,
    // interrupt
    output logic                      irq
);
    import stp_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [15:0]      ctrl_r;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0]      prdata_r;
    logic [31:0]      rd_mux;
    logic [31:0]      in_rdata;
    logic [31:0]      out_rdata;
    logic             rd_ack_r;
    logic             acc;
    logic             wr;
    logic             aligned;
    logic             hit_ctrl;
    logic             hit_stat;
    logic             hit_ist;
    logic             hit_imask;
    logic             hit_out;
    logic             hit_in;
    logic             mapped;
    logic [15:0]      stat_word;
    logic             ir;
    logic             ir_prev_r;
    logic             ir_rise;
    logic             init_active_r;
    logic [2:0]       init_cnt_r;
    logic             ia_r;
    logic             ia_set;
    logic             blk;
    stp_tx_state_t    tx_state_r;
    logic [LEN_W-1:0] tx_idx_r;
    logic [LEN_W-1:0] tx_len_r;
    logic [LEN_W-1:0] ol_len;
    logic [7:0]       tx_data_r;
    logic             tx_valid_r;
    logic             ta_r;
    logic             tr_pend;
    logic             tr_take;
    logic             tx_last;
    logic             tx_done;
    logic [LEN_W-1:0] fill_r;
    logic [LEN_W-1:0] il_r;
    logic             rr_r;
    logic             rx_pend_r;
    logic [7:0]       idle_cnt_r;
    logic             ra_pend;
    logic             ra_take;
    logic             rx_full;
    logic             rx_accept;
    logic             rx_drop;
    logic             rx_announce;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // apb decode and handshake
    // ----------------------------------------------------------------
    assign acc       = psel && penable;
    assign wr        = acc && pwrite;
    assign aligned   = (paddr[1:0] == 2'b00);
    assign hit_ctrl  = aligned && (paddr == OFF_CTRL);
    assign hit_stat  = aligned && (paddr == OFF_STAT);
    assign hit_ist   = aligned && (paddr == OFF_IRQ_ST);
    assign hit_imask = aligned && (paddr == OFF_IRQ_MASK);
    assign hit_out   = aligned && (paddr[11:6] == OFF_OUT_BASE[11:6]);
    assign hit_in    = aligned && (paddr[11:6] == OFF_IN_BASE[11:6]);
    assign mapped    = hit_ctrl || hit_stat || hit_ist || hit_imask
                       || hit_out || hit_in;
    assign pready    = pwrite || rd_ack_r;   // reads take one wait state
    assign pslverr   = acc && pready && !mapped;
    assign prdata    = prdata_r;

    // status word: length above, handshake bits below
    assign stat_word = {1'b0, il_r, 4'h0, rx_full, ia_r, rr_r, ta_r};

    // read data select
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux = {16'h0000, ctrl_r};
        else if (hit_stat)
            rd_mux = {16'h0000, stat_word};
        else if (hit_ist)
            rd_mux = {28'h0000000, irq_st_r};
        else if (hit_imask)
            rd_mux = {28'h0000000, irq_mask_r};
        else if (hit_in)
            rd_mux = in_rdata;
    end

    // read data captured in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ack_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (acc && !pwrite && !rd_ack_r)
        begin
            rd_ack_r <= 1'b1;
            prdata_r <= rd_mux;
        end
        else
            rd_ack_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // host control word; reserved bits stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= CTRL_RST;
        else if (wr && hit_ctrl)
            ctrl_r <= pwdata[15:0] & CTRL_WMASK;
    end

    // sticky events, write one to clear, set wins
    assign irq_set = {rx_drop, ia_set, rx_announce, tx_done};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_st_r <= IRQ_RST;
        else if (wr && hit_ist)
            irq_st_r <= (irq_st_r & ~pwdata[IRQ_W-1:0]) | irq_set;
        else
            irq_st_r <= irq_st_r | irq_set;
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_r <= IRQ_RST;
        else if (wr && hit_imask)
            irq_mask_r <= pwdata[IRQ_W-1:0];
    end

    assign irq = |(irq_st_r & irq_mask_r);

    // ----------------------------------------------------------------
    // init request and acknowledge
    // ----------------------------------------------------------------
    assign ir      = ctrl_r[CW_IR];
    assign ir_rise = ir && !ir_prev_r;
    assign blk     = init_active_r || ir;
    assign ia_set  = init_active_r && !ia_r
                     && (init_cnt_r == INIT_CYCLES - 3'h1);

    // previous init request level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ir_prev_r <= 1'b0;
        else
            ir_prev_r <= ir;
    end

    // init sequence: count, accept, release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_active_r <= 1'b0;
            init_cnt_r    <= 3'h0;
            ia_r          <= 1'b0;
        end
        else if (ir_rise && !init_active_r)
        begin
            init_active_r <= 1'b1;
            init_cnt_r    <= 3'h0;
            ia_r          <= 1'b0;
        end
        else if (ia_set)
            ia_r <= 1'b1;
        else if (init_active_r && !ia_r)
            init_cnt_r <= init_cnt_r + 3'h1;
        else if (ia_r && !ir)
        begin
            ia_r          <= 1'b0;
            init_active_r <= 1'b0;
        end
    end

    sequence s_init_start;
        $rose(init_active_r);
    endsequence
    sequence s_init_wait;
        !ia_r [*4] ##1 ia_r;
    endsequence
    a_ia_after_init: assert property (s_init_start |-> s_init_wait)
        else $error("init accepted not set after init time");
    a_ia_clears: assert property (ia_r && !ir |=> !ia_r)
        else $error("init accepted kept after request dropped");
    a_init_blocks: assert property (blk |=> !tx_valid_r && fill_r == 0)
        else $error("traffic or buffer alive during init");

    // ----------------------------------------------------------------
    // transmit side
    // ----------------------------------------------------------------
    stp_toggle_det u_tr_det
    (
        .pclk    (pclk),
        .presetn (presetn),
        .bit_in  (ctrl_r[CW_TR]),
        .consume (tr_take),
        .resync  (blk),
        .pending (tr_pend)
    );

    stp_word_mem u_out_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .we      ({4{wr && hit_out}}),
        .waddr   (paddr[5:2]),
        .wdata   (pwdata),
        .raddr   (tx_idx_r[5:2]),
        .rdata   (out_rdata)
    );

    // output length, clipped to the array size
    assign ol_len  = (ctrl_r[15:LEN_LSB] > {1'b0, FILL_MAX}) ? FILL_MAX
                     : ctrl_r[LEN_LSB +: LEN_W];
    assign tr_take = tr_pend && (tx_state_r == TX_IDLE) && !blk;
    assign tx_last = tx_valid_r && tx_ready
                     && (tx_idx_r + 7'h1 == tx_len_r);
    assign tx_done = (tr_take && ol_len == 0)
                     || ((tx_state_r == TX_SEND) && tx_last);
    assign tx_data  = tx_data_r;
    assign tx_valid = tx_valid_r;

    // transmit sequencer: fetch, load, hand each byte over
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state_r <= TX_IDLE;
            tx_idx_r   <= 7'h00;
            tx_len_r   <= 7'h00;
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
            ta_r       <= 1'b0;
        end
        else if (blk)
        begin
            tx_state_r <= TX_IDLE;
            tx_idx_r   <= 7'h00;
            tx_valid_r <= 1'b0;
        end
        else
        begin
            case (tx_state_r)
                TX_IDLE:
                begin
                    if (tr_take)
                    begin
                        tx_len_r <= ol_len;
                        tx_idx_r <= 7'h00;
                        if (ol_len == 0)
                            ta_r <= ~ta_r;
                        else
                            tx_state_r <= TX_FETCH;
                    end
                end
                TX_FETCH:
                    tx_state_r <= TX_LOAD;
                TX_LOAD:
                begin
                    tx_data_r  <= out_rdata[{tx_idx_r[1:0], 3'b000} +: 8];
                    tx_valid_r <= 1'b1;
                    tx_state_r <= TX_SEND;
                end
                TX_SEND:
                begin
                    if (tx_ready)
                    begin
                        tx_valid_r <= 1'b0;
                        if (tx_last)
                        begin
                            ta_r       <= ~ta_r;
                            tx_state_r <= TX_IDLE;
                        end
                        else
                        begin
                            tx_idx_r   <= tx_idx_r + 7'h1;
                            tx_state_r <= TX_FETCH;
                        end
                    end
                end
                default:
                    tx_state_r <= TX_IDLE;
            endcase
        end
    end

    a_ta_after_send: assert property (tx_last && !blk |=> $changed(ta_r))
        else $error("tx accepted not flipped after last byte");
    a_ta_only_done: assert property ($changed(ta_r) |-> $past(tx_done))
        else $error("tx accepted flipped without a finished block");
    a_tr_once: assert property (tr_take |=> !tr_take)
        else $error("one tx toggle taken twice");

    // ----------------------------------------------------------------
    // receive side
    // ----------------------------------------------------------------
    stp_toggle_det u_ra_det
    (
        .pclk    (pclk),
        .presetn (presetn),
        .bit_in  (ctrl_r[CW_RA]),
        .consume (ra_take),
        .resync  (blk),
        .pending (ra_pend)
    );

    stp_word_mem u_in_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (rx_accept ? (4'h1 << fill_r[1:0]) : 4'h0),
        .waddr   (fill_r[5:2]),
        .wdata   ({4{rx_data}}),
        .raddr   (paddr[5:2]),
        .rdata   (in_rdata)
    );

    assign ra_take     = ra_pend && !blk;
    assign rx_full     = (fill_r == FILL_MAX);
    // no copy while a block waits for its acknowledge
    assign rx_accept   = rx_valid && !blk && !rx_pend_r && !rx_full;
    assign rx_drop     = rx_valid && !blk && !rx_accept;
    assign rx_announce = !blk && !rx_pend_r && (fill_r != 0) && !rx_accept
                         && (rx_full || idle_cnt_r == RX_IDLE_CYCLES);

    // receive block: collect, announce, wait for acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fill_r    <= 7'h00;
            il_r      <= 7'h00;
            rr_r      <= 1'b0;
            rx_pend_r <= 1'b0;
        end
        else if (blk)
        begin
            fill_r    <= 7'h00;
            il_r      <= 7'h00;
            rx_pend_r <= 1'b0;
        end
        else if (ra_take && rx_pend_r)
        begin
            rx_pend_r <= 1'b0;
            fill_r    <= 7'h00;
        end
        else if (rx_announce)
        begin
            il_r      <= fill_r;
            rr_r      <= ~rr_r;
            rx_pend_r <= 1'b1;
        end
        else if (rx_accept)
            fill_r <= fill_r + 7'h1;
    end

    // quiet time on the receive stream before a block is announced
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt_r <= 8'h00;
        else if (blk || rx_accept)
            idle_cnt_r <= 8'h00;
        else if (idle_cnt_r != RX_IDLE_CYCLES)
            idle_cnt_r <= idle_cnt_r + 8'h01;
    end

    a_rr_with_len: assert property (rx_announce |=> $changed(rr_r)
        && stat_word[15:8] == {1'b0, $past(fill_r)})
        else $error("rx request or length wrong at announce");
    a_rx_hold_pend: assert property (rx_pend_r && !ra_pend && !blk
        |=> $stable(fill_r))
        else $error("receive data copied before acknowledge");
    a_buf_full: assert property (rx_full |-> stat_word[SW_BF] ##1
        (rx_full || $past(ra_take) || $past(blk)))
        else $error("buffer full flag or hold wrong");
    a_il_stable: assert property (rx_pend_r && !blk && !ra_take |=>
        $stable(stat_word[15:8]))
        else $error("input length moved during pending block");
    a_fill_bound: assert property (fill_r <= FILL_MAX)
        else $error("input array overrun");

endmodule

// ===== stp_pkg.sv
// package for the serial toggle handshake port: offsets, fields, counts
// assumes a 32-bit apb slave with word aligned registers
package stp_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_STAT     = 12'h004;
    localparam logic [11:0] OFF_IRQ_ST   = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
    localparam logic [11:0] OFF_OUT_BASE = 12'h040;
    localparam logic [11:0] OFF_IN_BASE  = 12'h080;

    // ----------------------------------------------------------------
    // control and status word fields
    // ----------------------------------------------------------------
    localparam int CW_TR   = 0;
    localparam int CW_RA   = 1;
    localparam int CW_IR   = 2;
    localparam int LEN_LSB = 8;
    localparam int SW_TA   = 0;
    localparam int SW_RR   = 1;
    localparam int SW_IA   = 2;
    localparam int SW_BF   = 3;
    localparam logic [15:0] CTRL_WMASK = 16'hff07;
    localparam logic [15:0] CTRL_RST   = 16'h0000;

    // ----------------------------------------------------------------
    // interrupt status bits
    // ----------------------------------------------------------------
    localparam int IRQ_TX   = 0;
    localparam int IRQ_RX   = 1;
    localparam int IRQ_INIT = 2;
    localparam int IRQ_OVF  = 3;
    localparam int IRQ_W    = 4;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // ----------------------------------------------------------------
    // array sizes and counts
    // ----------------------------------------------------------------
    localparam int LEN_W = 7;
    localparam logic [6:0] FILL_MAX       = 7'h40;
    localparam logic [2:0] INIT_CYCLES    = 3'h4;
    localparam logic [7:0] RX_IDLE_CYCLES = 8'h20;

    // ----------------------------------------------------------------
    // transmit sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_FETCH = 4'b0010,
        TX_LOAD  = 4'b0100,
        TX_SEND  = 4'b1000
    } stp_tx_state_t;

endpackage

// ===== stp_toggle_det.sv
// toggle detector: flags a handshake bit that differs from its last copy
// assumes bit_in comes from logic on pclk
`timescale 1ns/1ps
module stp_toggle_det
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // handshake bit and control
    input  wire logic bit_in,
    input  wire logic consume,
    input  wire logic resync,
    // pending event
    output logic      pending
);

    logic seen_r;

    // copy follows the bit when the event is taken or on resync
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_r <= 1'b0;
        else if (consume || resync)
            seen_r <= bit_in;
    end

    // any difference is one event until consumed
    assign pending = bit_in ^ seen_r;

endmodule

// ===== stp_word_mem.sv
// sixteen word memory with byte write enables and registered read data
// assumes both ports on pclk
`timescale 1ns/1ps
module stp_word_mem
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // write port
    input  wire logic [3:0]  we,
    input  wire logic [3:0]  waddr,
    input  wire logic [31:0] wdata,
    // read port
    input  wire logic [3:0]  raddr,
    output logic      [31:0] rdata
);

    logic [31:0] mem [16];

    // byte lane writes
    always_ff @(posedge pclk)
    begin
        for (int i = 0; i < 4; i++)
            if (we[i])
                mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
    end

    // registered read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata <= 32'h0000_0000;
        else
            rdata <= mem[raddr];
    end

endmodule

// ===== stp_serial_model.sv
// serial byte engine model on the far side of the port
// assumes pclk and presetn shared with the port; stalls every other cycle
`timescale 1ns/1ps
module stp_serial_model
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bytes from the port
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // bytes to the port
    output logic      [7:0] rx_data,
    output logic            rx_valid
);
    logic [7:0] got_q[$];

    // idle receive lines at time zero
    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end

    // ready on alternate cycles, bytes kept in arrival order
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_ready <= 1'b0;
        else
        begin
            tx_ready <= ~tx_ready;
            if (tx_valid && tx_ready)
                got_q.push_back(tx_data);
        end
    end

    // back to back burst of n bytes counting up from b0
    task automatic burst(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            rx_data <= b0 + 8'(i);
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~(b0 + 8'(n - 1)); // released line shows no stale byte
    endtask
endmodule

// ===== stp_port_test.sv
// self-checking bench of the toggle handshake port over apb
// assumes stp_port and stp_serial_model; 40 ns clock
`timescale 1ns/1ps
module stp_port_test;
    import stp_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        irq;
    logic [31:0] rd;
    logic        se;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;

    stp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .irq(irq));
    stp_serial_model m (.pclk(pclk), .presetn(presetn),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid));

    // ------------------------------------------------------------
    // clock, timeout and verdict
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // apb cycles and compares
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // setup, access until pready, release after the taking edge
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read, mask and compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] msk,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & msk, e);
    endtask

    // read status until a bit reaches v
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, OFF_STAT, 32'h0);
            n++;
        end
        while (rd[b] !== v && n < 300);
        chk({31'h0, rd[b]}, {31'h0, v});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFF_CTRL, 32'hffff, 32'h0);
        rchk(OFF_STAT, 32'hffff, 32'h0);
        rchk(12'h100, 32'hffffffff, 32'h0);
        chk({31'h0, se}, 32'h1);
        // transmit three bytes, stalled by the model
        apb(1'b1, OFF_IRQ_MASK, 32'hf);
        apb(1'b1, OFF_OUT_BASE, 32'h44332211);
        apb(1'b1, OFF_CTRL, 32'h0301);
        poll(0, 1'b1);
        chk(32'(m.got_q.size()), 32'h3);
        for (int i = 0; i < 3; i++)
            chk({24'h0, m.got_q.pop_front()}, 32'h11 * (i + 1));
        chk({31'h0, irq}, 32'h1);
        rchk(OFF_IRQ_ST, 32'hf, 32'h1);
        apb(1'b1, OFF_IRQ_ST, 32'h1);
        rchk(OFF_IRQ_ST, 32'hf, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // receive block of two, then a byte while pending
        m.burst(2, 8'ha0);
        poll(1, 1'b1);
        rchk(OFF_STAT, 32'hff00, 32'h0200);
        rchk(OFF_IN_BASE, 32'hffff, 32'ha1a0);
        m.burst(1, 8'hc0);
        rchk(OFF_IRQ_ST, 32'h8, 32'h8);
        rchk(OFF_IN_BASE, 32'hffff, 32'ha1a0);
        apb(1'b1, OFF_CTRL, 32'h0303);
        m.burst(1, 8'hb0);
        poll(1, 1'b0);
        rchk(OFF_STAT, 32'hff00, 32'h0100);
        rchk(OFF_IN_BASE, 32'hff, 32'hb0);
        // fill the array, one byte too many
        apb(1'b1, OFF_CTRL, 32'h0301);
        m.burst(65, 8'h00);
        poll(1, 1'b1);
        rchk(OFF_STAT, 32'hff08, 32'h4008);
        // init empties the input array, then traffic resumes
        apb(1'b1, OFF_CTRL, 32'h0305);
        poll(2, 1'b1);
        rchk(OFF_STAT, 32'h8, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0301);
        poll(2, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h0100);
        poll(0, 1'b0);
        chk({24'h0, m.got_q.pop_front()}, 32'h11);
        results();
    end
endmodule
